// *** core/abrk_pkg.sv ***
package abrk_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [4:0] TOP_STEP = 5'h1c;

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DELAY = 8'h04;
   localparam logic [7:0] ADDR_SENS = 8'h08;
   localparam logic [7:0] ADDR_MAP = 8'h0c;
   localparam logic [7:0] ADDR_SDS = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h14;

   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] DELAY_RST = 32'h0000_0a0a;
   localparam logic [31:0] SENS_RST = 32'h0000_0410;
   localparam logic [31:0] MAP_RST = 32'h0000_0103;
   localparam logic [31:0] SDS_RST = 32'h0000_0000;

   localparam int CTRL_ASYM_EN = 0;
   localparam int CTRL_ASYM_POS = 1;
   localparam int CTRL_DC_EN = 2;
   localparam int CTRL_SHUTTLE = 3;
   localparam int CTRL_CONST_DIST = 4;
   localparam int MAP_SHUNT_EN = 8;
   localparam int MAP_STOP_EN = 9;
   localparam int MAP_SHUNT_NODLY = 10;
   localparam int MAP_SHUNT_LIGHT = 11;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_BRAKE = 2'b01,
      ST_REVERSE = 2'b10,
      ST_LEAVE = 2'b11
   } abrk_state_t;
endpackage

// *** core/abrk_filt.sv ***
`timescale 1ns/1ps
module abrk_filt (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick,
   input wire logic cond,
   input wire logic [7:0] len,
   output logic stable
);
   logic stable_q, stable_d;
   logic [7:0] cnt_q, cnt_d;

   always_comb begin
      stable_d = stable_q;
      cnt_d = 8'h00;
      if (cond != stable_q) begin
         cnt_d = cnt_q;
         if (tick) begin
            if (cnt_q >= len) begin // [RULE18]
               stable_d = cond;
               cnt_d = 8'h00;
            end else begin
               cnt_d = cnt_q + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stable_q <= 1'b0;
         cnt_q <= 8'h00;
      end else begin
         stable_q <= stable_d;
         cnt_q <= cnt_d;
      end
   end

   assign stable = stable_q;

   property p_filt_change;
      @(posedge pclk) disable iff (!presetn)
      (stable_q != stable_d) |-> (tick && cond == stable_d && cnt_q >= len);
   endproperty
   a_filt_change: assert property (p_filt_change) else $error("filter changed early"); // [RULE18]
endmodule

// *** core/abrk_core.sv ***
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// [RULE1] asymmetric track enabled: brake with delay
// [RULE2] setting picks reduced negative or positive half
// [RULE3] asym section keeps functions, config, direction
// [RULE4] section left: accelerate back to command
// [RULE5] asymmetry threshold adjustable to ignore imbalance
// [RULE6] shuttle: stop, reverse, accelerate away
// [RULE7] pure dc track enabled: brake with delay
// [RULE8] dc section freezes function outputs
// [RULE9] dc section blocks functions, config, direction
// [RULE10] shared shunting function lights front, rear
// [RULE11] shunting function may bypass ramp delays
// [RULE12] per-output speed switching, selectable polarity
// [RULE13] one common speed switching threshold
// [RULE14] stop function brakes, release resumes
// [RULE15] stop function unmapped after reset
// [RULE16] delays pace one step per interval
// [RULE17] constant distance stretches low-speed intervals
// [RULE18] section declared only after filter time
module abrk_core #(
   parameter int TICK_CYC = abrk_pkg::TICK_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trk_sample,
   input wire logic [7:0] pos_amp,
   input wire logic [7:0] neg_amp,
   input wire logic [4:0] cmd_speed,
   input wire logic dir_in,
   input wire logic dir_strobe,
   input wire logic [7:0] fn_in,
   input wire logic fn_strobe,
   input wire logic cfg_wr_req,
   input wire logic [7:0] motor_volt,
   output logic [4:0] speed_step,
   output logic dir_fwd,
   output logic [5:0] fn_out,
   output logic cfg_wr_ack,
   output logic cfg_wr_nak
);
   function automatic logic [12:0] brake_interval(input logic [7:0] dly, input logic [4:0] start, input logic cd);
      logic [12:0] prod;
      prod = 13'(dly) * 13'(abrk_pkg::TOP_STEP);
      if (cd && start != 5'h00) begin
         brake_interval = prod / 13'(start);
      end else begin
         brake_interval = 13'(dly);
      end
   endfunction

   // apb register file
   logic [31:0] ctrl_q, ctrl_d, delay_q, delay_d, sens_q, sens_d, map_q, map_d, sds_q, sds_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d;
   logic hit, wr_now;
   logic [31:0] stat_word;

   // track detection
   logic asym_raw_q, asym_raw_d, dc_raw_q, dc_raw_d;
   logic asym_sec, dc_sec, pos_sel;
   logic [16:0] tick_cnt_q, tick_cnt_d;
   logic tick;

   // motion and functions
   abrk_pkg::abrk_state_t st_q, st_d;
   logic [4:0] speed_q, speed_d, brake_start_q, brake_start_d, target;
   logic [12:0] wait_q, wait_d, cur_int;
   logic dir_q, dir_d;
   logic [7:0] fn_state_q, fn_state_d;
   logic [5:0] fn_out_q, fn_out_d;
   logic ack_q, ack_d, nak_q, nak_d;
   logic shunt_on, stop_on, brake_eff, bypass, above;

   assign hit = (paddr == abrk_pkg::ADDR_CTRL) || (paddr == abrk_pkg::ADDR_DELAY) ||
                (paddr == abrk_pkg::ADDR_SENS) || (paddr == abrk_pkg::ADDR_MAP) ||
                (paddr == abrk_pkg::ADDR_SDS) || (paddr == abrk_pkg::ADDR_STAT);
   assign wr_now = psel && penable && pready_q && pwrite && hit;
   assign stat_word = {20'h00000, st_q, dc_sec, asym_sec, dir_q, speed_q, 2'b00};

   always_comb begin
      ctrl_d = ctrl_q;
      delay_d = delay_q;
      sens_d = sens_q;
      map_d = map_q;
      sds_d = sds_q;
      pready_d = psel && penable && !pready_q;
      pslverr_d = pready_d && !hit;
      prdata_d = 32'h0000_0000;
      if (pready_d && !pwrite) begin
         case (paddr)
            abrk_pkg::ADDR_CTRL: prdata_d = {27'h0000000, ctrl_q[4:0]};
            abrk_pkg::ADDR_DELAY: prdata_d = {16'h0000, delay_q[15:0]};
            abrk_pkg::ADDR_SENS: prdata_d = {16'h0000, sens_q[15:0]};
            abrk_pkg::ADDR_MAP: prdata_d = {20'h00000, map_q[11:0]};
            abrk_pkg::ADDR_SDS: prdata_d = {10'h000, sds_q[21:0]};
            abrk_pkg::ADDR_STAT: prdata_d = stat_word;
            default: prdata_d = 32'h0000_0000;
         endcase
      end
      if (wr_now) begin
         case (paddr)
            abrk_pkg::ADDR_CTRL: ctrl_d = {27'h0000000, pwdata[4:0]};
            abrk_pkg::ADDR_DELAY: delay_d = {16'h0000, pwdata[15:0]};
            abrk_pkg::ADDR_SENS: sens_d = {16'h0000, pwdata[15:0]}; // [RULE5]
            abrk_pkg::ADDR_MAP: map_d = {20'h00000, pwdata[11:0]};
            abrk_pkg::ADDR_SDS: sds_d = {10'h000, pwdata[21:0]}; // [RULE13]
            default: ctrl_d = ctrl_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= abrk_pkg::CTRL_RST;
         delay_q <= abrk_pkg::DELAY_RST;
         sens_q <= abrk_pkg::SENS_RST;
         map_q <= abrk_pkg::MAP_RST; // [RULE15]
         sds_q <= abrk_pkg::SDS_RST;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         delay_q <= delay_d;
         sens_q <= sens_d;
         map_q <= map_d;
         sds_q <= sds_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // amplitudes read only when trk_sample is high; front end paces trk_sample
   // reduced rail judged in travel direction, so a reversed loco drives out
   assign pos_sel = ctrl_q[abrk_pkg::CTRL_ASYM_POS] ^ !dir_q; // [RULE2] [RULE3]
   always_comb begin
      tick_cnt_d = tick_cnt_q + 17'h00001;
      tick = 1'b0;
      if (tick_cnt_q >= 17'(TICK_CYC - 1)) begin
         tick_cnt_d = 17'h00000;
         tick = 1'b1;
      end
      asym_raw_d = asym_raw_q;
      dc_raw_d = dc_raw_q;
      if (trk_sample) begin
         if (pos_sel) begin // [RULE2]
            asym_raw_d = {1'b0, neg_amp} > ({1'b0, pos_amp} + {1'b0, sens_q[7:0]}); // [RULE5]
         end else begin
            asym_raw_d = {1'b0, pos_amp} > ({1'b0, neg_amp} + {1'b0, sens_q[7:0]});
         end
         asym_raw_d = asym_raw_d && ctrl_q[abrk_pkg::CTRL_ASYM_EN]; // [RULE1]
         dc_raw_d = ctrl_q[abrk_pkg::CTRL_DC_EN] && ((pos_amp == 8'h00) != (neg_amp == 8'h00)); // [RULE7]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= 17'h00000;
         asym_raw_q <= 1'b0;
         dc_raw_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         asym_raw_q <= asym_raw_d;
         dc_raw_q <= dc_raw_d;
      end
   end

   abrk_filt u_asym_filt (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .cond(asym_raw_q),
      .len(sens_q[15:8]),
      .stable(asym_sec)
   );

   abrk_filt u_dc_filt (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .cond(dc_raw_q),
      .len(sens_q[15:8]),
      .stable(dc_sec)
   );

   assign shunt_on = map_q[abrk_pkg::MAP_SHUNT_EN] && fn_state_q[map_q[2:0]];
   assign stop_on = map_q[abrk_pkg::MAP_STOP_EN] && fn_state_q[map_q[6:4]]; // [RULE14]
   // leave state ignores the asym section so the reversed loco can drive out
   assign brake_eff = (asym_sec && st_q != abrk_pkg::ST_LEAVE) || dc_sec || stop_on; // [RULE1] [RULE7]
   assign bypass = shunt_on && map_q[abrk_pkg::MAP_SHUNT_NODLY]; // [RULE11]
   assign target = brake_eff ? 5'h00 : (shunt_on ? {1'b0, cmd_speed[4:1]} : cmd_speed); // [RULE4]
   assign cur_int = (speed_q > target) ?
                    brake_interval(delay_q[15:8], brake_start_q, ctrl_q[abrk_pkg::CTRL_CONST_DIST]) : // [RULE17]
                    13'(delay_q[7:0]);
   assign above = motor_volt > sds_q[7:0]; // [RULE13]

   always_comb begin
      st_d = st_q;
      speed_d = speed_q;
      wait_d = wait_q;
      brake_start_d = brake_start_q;
      dir_d = dir_q;
      fn_state_d = fn_state_q;
      ack_d = cfg_wr_req && !dc_sec; // [RULE3]
      nak_d = cfg_wr_req && dc_sec; // [RULE9]
      if (fn_strobe && !dc_sec) begin
         fn_state_d = fn_in; // [RULE3] [RULE8]
      end
      if (dir_strobe && !dc_sec) begin
         dir_d = dir_in; // [RULE3] [RULE9]
      end
      if (tick) begin
         if (speed_q == target) begin
            wait_d = 13'h0000;
         end else if (bypass || wait_q + 13'h0001 >= cur_int) begin // [RULE16]
            wait_d = 13'h0000;
            speed_d = (speed_q > target) ? speed_q - 5'h01 : speed_q + 5'h01;
         end else begin
            wait_d = wait_q + 13'h0001;
         end
      end
      case (st_q)
         abrk_pkg::ST_RUN: begin
            if (brake_eff) begin
               st_d = abrk_pkg::ST_BRAKE;
               brake_start_d = speed_q;
            end
         end
         abrk_pkg::ST_BRAKE: begin
            if (!brake_eff) begin
               st_d = abrk_pkg::ST_RUN;
            end else if (speed_q == 5'h00 && asym_sec && !dc_sec && ctrl_q[abrk_pkg::CTRL_SHUTTLE]) begin
               st_d = abrk_pkg::ST_REVERSE; // [RULE6]
            end
         end
         abrk_pkg::ST_REVERSE: begin
            dir_d = !dir_q; // [RULE6]
            st_d = abrk_pkg::ST_LEAVE;
         end
         abrk_pkg::ST_LEAVE: begin
            if (!asym_sec) begin
               st_d = abrk_pkg::ST_RUN;
            end else if (brake_eff) begin
               st_d = abrk_pkg::ST_BRAKE;
               brake_start_d = speed_q;
            end
         end
         default: st_d = abrk_pkg::ST_RUN;
      endcase
      // outputs follow functions 0..5; 0 front, 1 rear white light
      fn_out_d = fn_state_q[5:0];
      for (int i = 0; i < 6; i++) begin
         if (sds_q[8 + i]) begin
            fn_out_d[i] = fn_state_q[i] && (sds_q[16 + i] ? above : !above); // [RULE12]
         end
      end
      if (shunt_on && map_q[abrk_pkg::MAP_SHUNT_LIGHT]) begin
         fn_out_d[1:0] = 2'b11; // [RULE10]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= abrk_pkg::ST_RUN;
         speed_q <= 5'h00;
         wait_q <= 13'h0000;
         brake_start_q <= 5'h00;
         dir_q <= 1'b1;
         fn_state_q <= 8'h00;
         fn_out_q <= 6'h00;
         ack_q <= 1'b0;
         nak_q <= 1'b0;
      end else begin
         st_q <= st_d;
         speed_q <= speed_d;
         wait_q <= wait_d;
         brake_start_q <= brake_start_d;
         dir_q <= dir_d;
         fn_state_q <= fn_state_d;
         fn_out_q <= fn_out_d;
         ack_q <= ack_d;
         nak_q <= nak_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign speed_step = speed_q;
   assign dir_fwd = dir_q;
   assign fn_out = fn_out_q;
   assign cfg_wr_ack = ack_q;
   assign cfg_wr_nak = nak_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_shuttle_stop;
      st_q == abrk_pkg::ST_BRAKE && speed_q == 5'h00 && asym_sec && !dc_sec && ctrl_q[abrk_pkg::CTRL_SHUTTLE];
   endsequence
   sequence s_turn;
      st_q == abrk_pkg::ST_REVERSE ##1 st_q == abrk_pkg::ST_LEAVE && dir_q != $past(dir_q, 2);
   endsequence

   property p_asym_brake;
      asym_sec && st_q != abrk_pkg::ST_LEAVE |-> target == 5'h00;
   endproperty
   a_asym_brake: assert property (p_asym_brake) else $error("asym section not braking"); // [RULE1]
   property p_sens;
      trk_sample && !pos_sel && pos_amp <= neg_amp |=> !asym_raw_q;
   endproperty
   a_sens: assert property (p_sens) else $error("asym seen without imbalance"); // [RULE5]
   property p_asym_dir;
      dir_strobe && !dc_sec && st_q != abrk_pkg::ST_REVERSE |=> dir_q == $past(dir_in);
   endproperty
   a_asym_dir: assert property (p_asym_dir) else $error("direction change refused"); // [RULE3]
   property p_shuttle;
      s_shuttle_stop |=> s_turn;
   endproperty
   a_shuttle: assert property (p_shuttle) else $error("shuttle did not reverse"); // [RULE6]
   property p_dc_fn;
      dc_sec |=> $stable(fn_state_q);
   endproperty
   a_dc_fn: assert property (p_dc_fn) else $error("functions changed in dc section"); // [RULE8]
   property p_dc_cfg;
      cfg_wr_req && dc_sec |=> nak_q && !ack_q;
   endproperty
   a_dc_cfg: assert property (p_dc_cfg) else $error("config write accepted in dc section"); // [RULE9]
   property p_step_down;
      tick && speed_q > target && !bypass && wait_q + 13'h0001 >= cur_int |=> speed_q == $past(speed_q) - 5'h01;
   endproperty
   a_step_down: assert property (p_step_down) else $error("missed step down"); // [RULE16]
   property p_step_hold;
      tick && speed_q != target && !bypass && wait_q + 13'h0001 < cur_int |=> $stable(speed_q);
   endproperty
   a_step_hold: assert property (p_step_hold) else $error("stepped before interval"); // [RULE16]
   property p_stop;
      stop_on |-> target == 5'h00;
   endproperty
   a_stop: assert property (p_stop) else $error("stop function not braking"); // [RULE14]
   property p_apb;
      psel && penable && !pready_q |=> pready_q;
   endproperty
   a_apb: assert property (p_apb) else $error("apb answer late");
endmodule

// *** verification/abrk_track_model.sv ***
`timescale 1ns/1ps
module abrk_track_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] mode,
   output logic trk_sample,
   output logic [7:0] pos_amp,
   output logic [7:0] neg_amp
);
   logic [1:0] cnt_q;
   logic [15:0] amp_d;
   always_comb begin
      case (mode)
         3'h1: amp_d = 16'hc8c0; // slight imbalance only
         3'h2: amp_d = 16'hc880;
         3'h3: amp_d = 16'h80c8;
         3'h4: amp_d = 16'hc800; // pure dc, one polarity
         3'h5: amp_d = 16'h00c8;
         default: amp_d = 16'hc8c8;
      endcase
   end
   // amplitudes scrambled between samples so no stale value is trusted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 2'h0;
         trk_sample <= 1'b0;
         pos_amp <= 8'h00;
         neg_amp <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         trk_sample <= (cnt_q == 2'h3);
         pos_amp <= (cnt_q == 2'h3) ? amp_d[15:8] : ~pos_amp;
         neg_amp <= (cnt_q == 2'h3) ? amp_d[7:0] : ~neg_amp;
      end
   end
endmodule

// *** verification/automatic_braking_control_test.sv ***
`timescale 1ns/1ps
module automatic_braking_control_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0] paddr, pos_amp, neg_amp, fn_in, motor_volt;
   logic [31:0] pwdata, prdata, rd;
   logic trk_sample, dir_in, dir_strobe, fn_strobe, cfg_wr_req, dir_fwd, cfg_wr_ack, cfg_wr_nak;
   logic [4:0] cmd_speed, speed_step;
   logic [5:0] fn_out;
   logic [2:0] mode;
   int n_mismatch = 0;
   int samples_checked = 0;
   int n;

   abrk_core #(.TICK_CYC(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .trk_sample, .pos_amp, .neg_amp, .cmd_speed, .dir_in,
      .dir_strobe, .fn_in, .fn_strobe, .cfg_wr_req, .motor_volt, .speed_step, .dir_fwd,
      .fn_out, .cfg_wr_ack, .cfg_wr_nak);
   abrk_track_model trk (.pclk, .presetn, .mode, .trk_sample, .pos_amp, .neg_amp);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 20) begin
         check("pready", 0, 1);
         end_of_test();
      end
   endtask

   task automatic wait_speed(input logic [4:0] exp);
      for (n = 0; n < 1500 && speed_step !== exp; n++) @(posedge pclk);
      check("speed_step", speed_step, exp);
      if (speed_step !== exp)
         end_of_test();
   endtask

   task automatic wait_fn(input logic [5:0] m, input logic [5:0] exp);
      for (int i = 0; i < 60 && (fn_out & m) !== exp; i++) @(posedge pclk);
      check("fn_out", fn_out & m, exp);
      if ((fn_out & m) !== exp)
         end_of_test();
   endtask

   task automatic set_fn(input logic [7:0] f);
      @(posedge pclk);
      fn_in <= f;
      fn_strobe <= 1'b1;
      @(posedge pclk);
      fn_strobe <= 1'b0;
   endtask

   task automatic set_dir(input logic d);
      @(posedge pclk);
      dir_in <= d;
      dir_strobe <= 1'b1;
      @(posedge pclk);
      dir_strobe <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   task automatic cfg_probe(input logic ack);
      logic a, k;
      a = 1'b0;
      k = 1'b0;
      @(posedge pclk);
      cfg_wr_req <= 1'b1;
      @(posedge pclk);
      cfg_wr_req <= 1'b0;
      repeat (3) begin
         @(posedge pclk);
         a |= cfg_wr_ack;
         k |= cfg_wr_nak;
      end
      check("cfg answer", {a, k}, {ack, ~ack});
   endtask

   task automatic t_reset();
      logic [31:0] v[5];
      v = '{abrk_pkg::CTRL_RST, abrk_pkg::DELAY_RST, abrk_pkg::SENS_RST, abrk_pkg::MAP_RST,
         abrk_pkg::SDS_RST};
      check("dir_fwd", dir_fwd, 1);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         check("reset value", rd, v[i]);
      end
      apb(1'b1, 8'h18, 32'hffff_ffff);
      apb(1'b0, 8'h18, 32'h0);
      check("unmapped", {e, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, abrk_pkg::ADDR_DELAY, 32'h0000_0302);
      cmd_speed <= 5'h08;
      wait_speed(5'h08);
      check("accel time", n >= 120 && n <= 200, 1);
      $display("test reset and ramp done");
   endtask

   task automatic t_asym();
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, abrk_pkg::ADDR_CTRL, 32'h1 | (p << 1));
         mode <= p ? 3'h2 : 3'h3;
         repeat (150) @(posedge pclk);
         check("wrong half", speed_step, 8);
         mode <= p ? 3'h3 : 3'h2;
         wait_speed(5'h00);
         check("brake time", n >= 200, 1);
         set_fn(8'h01);
         wait_fn(6'h01, 6'h01);
         cfg_probe(1'b1);
         set_dir(1'b0);
         check("dir_fwd", dir_fwd, 0);
         wait_speed(5'h08);
         mode <= 3'h0;
         wait_speed(5'h08);
         set_dir(1'b1);
         set_fn(8'h00);
      end
      $display("test asymmetric done");
   endtask

   task automatic t_filter();
      apb(1'b1, abrk_pkg::ADDR_CTRL, 32'h1);
      // one tick per brake step, so an unfiltered burst would show
      apb(1'b1, abrk_pkg::ADDR_DELAY, 32'h0000_0102);
      mode <= 3'h1;
      repeat (200) @(posedge pclk);
      check("imbalance", speed_step, 8);
      mode <= 3'h2;
      repeat (25) @(posedge pclk);
      mode <= 3'h0;
      repeat (200) @(posedge pclk);
      check("short burst", speed_step, 8);
      apb(1'b1, abrk_pkg::ADDR_DELAY, 32'h0000_0302);
      $display("test filter done");
   endtask

   task automatic t_dc();
      apb(1'b1, abrk_pkg::ADDR_CTRL, 32'h4);
      set_fn(8'h01);
      for (int m = 4; m < 6; m++) begin
         mode <= 3'(m);
         wait_speed(5'h00);
         apb(1'b0, abrk_pkg::ADDR_STAT, 32'h0);
         check("status", rd, 32'h0000_0680);
         set_fn(8'h02);
         set_dir(1'b0);
         check("frozen fn", fn_out[1:0], 1);
         check("dir_fwd", dir_fwd, 1);
         cfg_probe(1'b0);
         mode <= 3'h0;
         wait_speed(5'h08);
         set_fn(8'h01);
      end
      set_fn(8'h00);
      $display("test dc done");
   endtask

   task automatic t_shuttle();
      apb(1'b1, abrk_pkg::ADDR_CTRL, 32'h9);
      for (int k = 0; k < 2; k++) begin
         mode <= k ? 3'h3 : 3'h2;
         wait_speed(5'h00);
         for (int i = 0; i < 200 && dir_fwd !== 1'(k); i++) @(posedge pclk);
         check("reversed", dir_fwd, k);
         if (dir_fwd !== 1'(k))
            end_of_test();
         wait_speed(5'h08);
         mode <= 3'h0;
         repeat (100) @(posedge pclk);
      end
      $display("test shuttle done");
   endtask

   task automatic t_stop_shunt();
      apb(1'b1, abrk_pkg::ADDR_CTRL, 32'h10);
      apb(1'b1, abrk_pkg::ADDR_MAP, 32'h353);
      set_fn(8'h20);
      wait_speed(5'h00);
      check("long brake", n >= 600, 1);
      set_fn(8'h00);
      wait_speed(5'h08);
      apb(1'b1, abrk_pkg::ADDR_MAP, 32'hd03);
      set_fn(8'h08);
      wait_fn(6'h03, 6'h03);
      wait_speed(5'h04);
      check("no ramp", n <= 80, 1);
      set_fn(8'h00);
      wait_speed(5'h08);
      $display("test stop and shunting done");
   endtask

   task automatic t_sds();
      apb(1'b1, abrk_pkg::ADDR_SDS, 32'h0010_3080);
      motor_volt <= 8'h40;
      set_fn(8'h30);
      wait_fn(6'h30, 6'h20);
      motor_volt <= 8'hc0;
      wait_fn(6'h30, 6'h10);
      $display("test speed switching done");
   endtask

   initial begin
      {psel, penable, pwrite, dir_strobe, fn_strobe, cfg_wr_req, presetn} = 7'h00;
      {paddr, pwdata, fn_in, motor_volt} = 56'h0;
      dir_in = 1'b1;
      cmd_speed = 5'h00;
      mode = 3'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_asym();
      t_filter();
      t_dc();
      t_shuttle();
      t_stop_shunt();
      t_sds();
      end_of_test();
   end
endmodule
